// ### sim/dram_refresh_scheduling_tb_top.sv
// self-checking bench: controller and device joined over the refresh link
`timescale 1ns/1ps
`include "lpr_defines.svh"
module dram_refresh_scheduling_tb_top;
    logic core_clk, rst, cmd_valid, pb_mode, sr_req, cmd_done, ref_issued;
    logic ctl_sref, dev_sref, cmd_err;
    lpr_pkg::lpr_op_t cmd_op;
    logic [2:0] cmd_bank, ref_ptr, dev_ref_bank;
    logic [3:0] ref_owed;
    logic [7:0] bank_idle, bank_refr;
    int mismatches, num_checks;

    lpr_link_if lnk();
    lpr_ctl u_lpr_ctl (.core_clk_in(core_clk), .rst_in(rst), .link(lnk),
        .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_bank_in(cmd_bank),
        .pb_mode_in(pb_mode), .sr_req_in(sr_req), .cmd_done_out(cmd_done),
        .ref_issued_out(ref_issued), .ref_ptr_out(ref_ptr), .ref_owed_out(ref_owed),
        .in_sref_out(ctl_sref));
    lpr_dev u_lpr_dev (.core_clk_in(core_clk), .rst_in(rst), .link(lnk),
        .bank_idle_out(bank_idle), .bank_refreshing_out(bank_refr),
        .ref_bank_out(dev_ref_bank), .in_sref_out(dev_sref), .cmd_err_out(cmd_err));
    lpr_link_monitor u_lpr_link_monitor (.core_clk_in(core_clk), .rst_in(rst),
        .cke(lnk.cke), .cs_n(lnk.cs_n), .ca(lnk.ca), .ba(lnk.ba));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wait_ref(input int lim, input logic ab);
        int i;
        for (i = 0; i < lim; i++) begin
            tick(1);
            if (ref_issued === 1'b1 && lnk.ca[3] === ab) break;
        end
        chk({7'h0, ref_issued}, 8'h01);
        chk({4'h0, lnk.ca}, {4'h0, ab, 3'h4});
        chk({7'h0, lnk.cs_n}, 8'h00);
    endtask

    task automatic user_cmd(input lpr_pkg::lpr_op_t op, input logic [3:0] code,
        input logic [2:0] bank);
        int i;
        cmd_op = op;
        cmd_bank = bank;
        cmd_valid = 1'b1;
        for (i = 0; i < 100 && cmd_done !== 1'b1; i++) tick(1);
        chk({7'h0, cmd_done}, 8'h01);
        chk({4'h0, lnk.ca}, {4'h0, code});
        chk({5'h0, lnk.ba}, {5'h0, bank});
        cmd_valid = 1'b0;
        tick(1);
    endtask

    task automatic wait_sref(input logic lvl);
        int i;
        for (i = 0; i < 300 && ctl_sref !== lvl; i++) tick(1);
        chk({7'h0, ctl_sref}, {7'h0, lvl});
        chk({7'h0, lnk.cke}, {7'h0, !lvl});
    endtask

    // nine per-bank refreshes: wrap of the counter, concurrency on other banks
    task automatic t_perbank();
        int i;
        int exp;
        user_cmd(lpr_pkg::OP_ACT, `LPR_CA_ACT, 3'h0);
        for (i = 0; i < 9; i++) begin
            exp = i % 8;
            wait_ref(400, 1'b0);
            chk({7'h0, bank_idle[exp]}, 8'h01);
            tick(1);
            chk(bank_refr, 8'h01 << exp);
            chk({5'h0, dev_ref_bank}, 8'((exp + 1) % 8));
            chk({5'h0, ref_ptr}, 8'((exp + 1) % 8));
            if (i == 2) begin
                user_cmd(lpr_pkg::OP_ACT, `LPR_CA_ACT, 3'h6);
                chk({7'h0, bank_refr[2]}, 8'h01);
                tick(14);
                chk(bank_refr, 8'h00);
                chk({7'h0, bank_idle[2]}, 8'h01);
            end
        end
    endtask

    // all-bank refresh with a bank open: precharge-all first, counter cleared
    task automatic t_allbank();
        pb_mode = 1'b0;
        user_cmd(lpr_pkg::OP_ACT, `LPR_CA_ACT, 3'h3);
        wait_ref(2000, 1'b1);
        chk(bank_idle, 8'hFF);
        tick(1);
        chk(bank_refr, 8'hFF);
        chk({5'h0, dev_ref_bank}, 8'h00);
        chk({5'h0, ref_ptr}, 8'h00);
        tick(25);
        chk(bank_refr, 8'hFF);
        tick(1);
        chk(bank_refr, 8'h00);
        chk(bank_idle, 8'hFF);
    endtask

    // self refresh clears both counters; first refresh after exit hits bank 0
    task automatic t_sref();
        pb_mode = 1'b1;
        wait_ref(400, 1'b0);
        tick(1);
        chk({5'h0, dev_ref_bank}, 8'h01);
        user_cmd(lpr_pkg::OP_ACT, `LPR_CA_ACT, 3'h5);
        user_cmd(lpr_pkg::OP_PRE, `LPR_CA_PRE, 3'h5);
        user_cmd(lpr_pkg::OP_PREALL, `LPR_CA_PREALL, 3'h0);
        user_cmd(lpr_pkg::OP_NOP, `LPR_CA_NOP, 3'h0);
        sr_req = 1'b1;
        wait_sref(1'b1);
        tick(1);
        chk({7'h0, dev_sref}, 8'h01);
        tick(20);
        sr_req = 1'b0;
        wait_sref(1'b0);
        tick(1);
        chk({5'h0, dev_ref_bank}, 8'h00);
        chk({5'h0, ref_ptr}, 8'h00);
        chk({4'h0, ref_owed}, 8'h01);
        wait_ref(200, 1'b0);
        tick(1);
        chk(bank_refr, 8'h01);
    endtask

    // sampled mid-cycle so the error flop has settled
    always @(negedge core_clk) begin
        if (!rst) begin
            chk({7'h0, cmd_err}, 8'h00);
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        test_done();
    end

    initial begin
        mismatches = 0;
        num_checks = 0;
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = lpr_pkg::OP_NOP;
        cmd_bank = 3'h0;
        pb_mode = 1'b1;
        sr_req = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        chk({lnk.cke, lnk.cs_n, 2'h0, lnk.ca}, 8'hC7);
        chk(bank_idle, 8'hFF);
        chk({ref_owed, 1'b0, cmd_done, ref_issued, ctl_sref}, 8'h00);
        rst = 1'b0;
        tick(1);
        chk({3'h0, lnk.cs_n, lnk.ca}, {4'h0, `LPR_CA_RESET});
        t_perbank();
        t_allbank();
        t_sref();
        test_done();
    end
endmodule

// ### sim/lpr_link_monitor.sv
// wire-level refresh scheduling checks on the controller/device link
`timescale 1ns/1ps
`include "lpr_defines.svh"
module lpr_link_monitor (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic [3:0] ca,
    input wire logic [2:0] ba
);
    localparam int RFCAB = `LPR_RFCAB_CYC;
    localparam int RFCPB = `LPR_RFCPB_CYC;
    localparam int RRD = `LPR_RRD_CYC;
    localparam int RP = `LPR_RP_CYC;
    logic sel, ref_ab, ref_pb, act, pre, pre_all, rst_cmd, cke_q, pre_was_all;
    logic [7:0] since_ab, since_pb, since_act, since_pre, open;
    logic [2:0] ptr, pb_bank, pre_bank;

    assign sel = cke && !cs_n;
    assign ref_ab = sel && ca[2:0] == `LPR_CA_REF && ca[3];
    assign ref_pb = sel && ca[2:0] == `LPR_CA_REF && !ca[3];
    assign act = sel && ca == `LPR_CA_ACT;
    assign pre = sel && ca == `LPR_CA_PRE;
    assign pre_all = sel && ca == `LPR_CA_PREALL;
    assign rst_cmd = sel && ca == `LPR_CA_RESET;

    function automatic logic [7:0] step(input logic [7:0] c);
        return (c == 8'hFF) ? c : c + 8'h01;
    endfunction

    // cycles since the last command of each kind, saturating
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            since_ab <= 8'hFF;
            since_pb <= 8'hFF;
            since_act <= 8'hFF;
            since_pre <= 8'hFF;
        end else begin
            since_ab <= ref_ab ? 8'h01 : step(since_ab);
            since_pb <= ref_pb ? 8'h01 : step(since_pb);
            since_act <= act ? 8'h01 : step(since_act);
            since_pre <= (pre || pre_all) ? 8'h01 : step(since_pre);
        end
    end

    // open banks as seen on the wire
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            open <= 8'h00;
        end else if (act) begin
            open[ba] <= 1'b1;
        end else if (pre) begin
            open[ba] <= 1'b0;
        end else if (pre_all || rst_cmd) begin
            open <= 8'h00;
        end
    end

    // mirror of the device bank counter plus last targets
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ptr <= 3'h0;
            cke_q <= 1'b1;
            pb_bank <= 3'h0;
            pre_bank <= 3'h0;
            pre_was_all <= 1'b0;
        end else begin
            cke_q <= cke;
            if (rst_cmd || ref_ab || (cke && !cke_q)) begin
                ptr <= 3'h0;
            end else if (ref_pb) begin
                ptr <= ptr + 3'h1;
            end
            if (ref_pb) begin
                pb_bank <= ptr;
            end
            if (pre) begin
                pre_bank <= ba;
                pre_was_all <= 1'b0;
            end else if (pre_all) begin
                pre_was_all <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_ab_issue;
        ref_ab;
    endsequence
    sequence s_no_use;
        !(ref_ab || ref_pb || act);
    endsequence

    a_ab_quiet_run: assert property (s_ab_issue |=> s_no_use [*8])
        else $error("command too soon after all-bank refresh");
    a_ab_to_refresh: assert property ((ref_ab || ref_pb) |-> since_ab >= RFCAB)
        else $error("refresh inside all-bank refresh cycle");
    a_ab_to_act: assert property (act |-> since_ab >= RFCAB)
        else $error("activate inside all-bank refresh cycle");
    a_pb_to_refresh: assert property ((ref_ab || ref_pb) |-> since_pb >= RFCPB)
        else $error("refresh inside per-bank refresh cycle");
    a_pb_to_act: assert property (act |-> since_pb >= ((ba == pb_bank) ? RFCPB : RRD))
        else $error("activate too soon after per-bank refresh");
    a_act_to_pb: assert property (ref_pb |-> since_act >= RRD)
        else $error("per-bank refresh too soon after activate");
    a_pb_idle_bank: assert property (ref_pb |-> !open[ptr])
        else $error("per-bank refresh to an open bank");
    a_pb_after_pre: assert property (ref_pb |->
        since_pre >= RP || (!pre_was_all && pre_bank != ptr))
        else $error("per-bank refresh inside precharge period");
    a_ab_all_idle: assert property (ref_ab |-> open == 8'h00)
        else $error("all-bank refresh with a bank open");
    a_ab_after_pre: assert property (ref_ab |-> since_pre >= RP)
        else $error("all-bank refresh inside precharge period");
endmodule

// ### verilog/lpr_ctl.sv
// memory controller end: refresh scheduling, bank tracking and command issue
`timescale 1ns/1ps
`include "lpr_defines.svh"
module lpr_ctl (
    input wire logic core_clk_in,
    input wire logic rst_in,
    lpr_link_if.ctl link,
    input wire logic cmd_valid_in,
    input wire lpr_pkg::lpr_op_t cmd_op_in,
    input wire logic [2:0] cmd_bank_in,
    input wire logic pb_mode_in,
    input wire logic sr_req_in,
    output logic cmd_done_out,
    output logic ref_issued_out,
    output logic [2:0] ref_ptr_out,
    output logic [3:0] ref_owed_out,
    output logic in_sref_out
);
    localparam logic [7:0] RFCAB = 8'(`LPR_RFCAB_CYC);
    localparam logic [7:0] RFCPB = 8'(`LPR_RFCPB_CYC);
    localparam logic [7:0] RRD = 8'(`LPR_RRD_CYC);
    localparam logic [7:0] RP = 8'(`LPR_RP_CYC);
    localparam logic [10:0] REFI = 11'(`LPR_REFI_CYC);
    localparam logic [10:0] REFI_PB = 11'(`LPR_REFI_PB_CYC);
    localparam logic [3:0] OWED_MAX = 4'(`LPR_OWED_MAX);

    function automatic logic met(input logic [7:0] cnt, input logic [7:0] lim);
        met = (cnt >= lim);
    endfunction

    function automatic logic [7:0] sat_inc(input logic [7:0] cnt);
        sat_inc = (cnt == 8'hFF) ? cnt : cnt + 8'h01;
    endfunction

    lpr_pkg::lpr_ctl_state_t state, next_state;
    logic [7:0] since_ab, since_pb, since_act;
    logic [7:0] rp_cnt [8];
    logic [7:0] open_bank;
    logic [2:0] last_pb, pre_bank;
    logic [10:0] refi_cnt, refi_lim;
    logic refi_tick, rp_all_ok, pb_ok, ab_ok, act_ok;
    logic do_pb, do_ab, do_act, do_pre, do_preall, do_reset, do_sr_in, do_sr_out, take_user;
    logic next_cke, next_cs_n;
    logic [3:0] next_ca;
    logic [2:0] next_ba;

    always_comb begin
        rp_all_ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rp_all_ok = rp_all_ok & met(rp_cnt[i], RP);
        end
    end

    assign pb_ok = met(since_ab, RFCAB) & met(since_pb, RFCPB) & met(since_act, RRD)
        & met(rp_cnt[ref_ptr_out], RP) & ~open_bank[ref_ptr_out];
    assign ab_ok = met(since_ab, RFCAB) & met(since_pb, RFCPB) & rp_all_ok & ~(|open_bank);
    assign act_ok = met(since_ab, RFCAB) & met(since_act, RRD) & met(rp_cnt[cmd_bank_in], RP)
        & ~open_bank[cmd_bank_in] & ~(cmd_bank_in == last_pb && !met(since_pb, RFCPB));

    assign refi_lim = pb_mode_in ? REFI_PB : REFI;
    assign refi_tick = (state == lpr_pkg::ST_RUN) && (refi_cnt >= refi_lim - 11'h001);

    always_comb begin
        next_state = state;
        do_pb = 1'b0;
        do_ab = 1'b0;
        do_act = 1'b0;
        do_pre = 1'b0;
        do_preall = 1'b0;
        do_reset = 1'b0;
        do_sr_in = 1'b0;
        do_sr_out = 1'b0;
        take_user = 1'b0;
        pre_bank = ref_ptr_out;
        next_cke = 1'b1;
        case (state)
            lpr_pkg::ST_INIT: begin
                do_reset = 1'b1;
                next_state = lpr_pkg::ST_RUN;
            end
            lpr_pkg::ST_RUN: begin
                if (ref_owed_out != 4'h0) begin
                    if (pb_mode_in) begin
                        if (open_bank[ref_ptr_out]) begin
                            do_pre = 1'b1;
                        end else begin
                            do_pb = pb_ok;
                        end
                    end else if (|open_bank) begin
                        do_preall = 1'b1;
                    end else begin
                        do_ab = ab_ok;
                    end
                end else if (sr_req_in && ab_ok) begin
                    do_sr_in = 1'b1;
                    next_cke = 1'b0;
                    next_state = lpr_pkg::ST_SREF;
                end else if (cmd_valid_in && !cmd_done_out) begin
                    case (cmd_op_in)
                        lpr_pkg::OP_ACT: begin
                            do_act = act_ok;
                        end
                        lpr_pkg::OP_PRE: begin
                            do_pre = 1'b1;
                            pre_bank = cmd_bank_in;
                        end
                        lpr_pkg::OP_PREALL: begin
                            do_preall = 1'b1;
                        end
                        default: begin
                            do_pre = 1'b0;
                        end
                    endcase
                    take_user = do_act | do_pre | do_preall | (cmd_op_in == lpr_pkg::OP_NOP);
                end
            end
            lpr_pkg::ST_SREF: begin
                next_cke = 1'b0;
                if (!sr_req_in) begin
                    do_sr_out = 1'b1;
                    next_cke = 1'b1;
                    next_state = lpr_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = lpr_pkg::ST_INIT;
            end
        endcase
    end

    always_comb begin
        next_cs_n = 1'b0;
        next_ba = 3'h0;
        if (do_pb || do_ab || do_sr_in) begin
            next_ca = {do_ab | do_sr_in, `LPR_CA_REF};
        end else if (do_act) begin
            next_ca = `LPR_CA_ACT;
            next_ba = cmd_bank_in;
        end else if (do_pre) begin
            next_ca = `LPR_CA_PRE;
            next_ba = pre_bank;
        end else if (do_preall) begin
            next_ca = `LPR_CA_PREALL;
        end else if (do_reset) begin
            next_ca = `LPR_CA_RESET;
        end else begin
            next_ca = `LPR_CA_NOP;
            next_cs_n = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= lpr_pkg::ST_INIT;
            link.cke <= 1'b1;
            link.cs_n <= 1'b1;
            link.ca <= `LPR_CA_NOP;
            link.ba <= 3'h0;
        end else begin
            state <= next_state;
            link.cke <= next_cke;
            link.cs_n <= next_cs_n;
            link.ca <= next_ca;
            link.ba <= next_ba;
        end
    end

    // separation timers saturate so that long idle times read as satisfied
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            since_ab <= 8'hFF;
            since_pb <= 8'hFF;
            since_act <= 8'hFF;
            for (int i = 0; i < 8; i++) begin
                rp_cnt[i] <= 8'hFF;
            end
        end else begin
            // refreshes, activates and self-refresh entry after exit from self refresh are also held off for a full all-bank cycle
            since_ab <= (do_ab || do_sr_out) ? 8'h00 : sat_inc(since_ab);
            since_pb <= do_pb ? 8'h00 : sat_inc(since_pb);
            since_act <= (do_act || do_pb) ? 8'h00 : sat_inc(since_act);
            for (int i = 0; i < 8; i++) begin
                if (do_preall || (do_pre && pre_bank == 3'(i))) begin
                    rp_cnt[i] <= 8'h00;
                end else begin
                    rp_cnt[i] <= sat_inc(rp_cnt[i]);
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            open_bank <= 8'h00;
        end else if (do_reset || do_preall) begin
            open_bank <= 8'h00;
        end else if (do_act) begin
            open_bank[cmd_bank_in] <= 1'b1;
        end else if (do_pre) begin
            open_bank[pre_bank] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ref_ptr_out <= 3'h0;
            last_pb <= 3'h0;
        end else if (do_reset || do_ab || do_sr_out) begin
            ref_ptr_out <= 3'h0;
        end else if (do_pb) begin
            ref_ptr_out <= ref_ptr_out + 3'h1;
            last_pb <= ref_ptr_out;
        end
    end

    // one refresh owed per interval; the cap keeps catch-up below the burst limit
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            refi_cnt <= 11'h000;
            ref_owed_out <= 4'h0;
        end else if (state != lpr_pkg::ST_RUN) begin
            refi_cnt <= 11'h000;
            ref_owed_out <= do_sr_out ? 4'h1 : 4'h0;
        end else begin
            refi_cnt <= refi_tick ? 11'h000 : refi_cnt + 11'h001;
            if (refi_tick && !(do_pb || do_ab) && ref_owed_out != OWED_MAX) begin
                ref_owed_out <= ref_owed_out + 4'h1;
            end else if (!refi_tick && (do_pb || do_ab)) begin
                ref_owed_out <= ref_owed_out - 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_done_out <= 1'b0;
            ref_issued_out <= 1'b0;
            in_sref_out <= 1'b0;
        end else begin
            cmd_done_out <= take_user;
            ref_issued_out <= do_pb | do_ab;
            in_sref_out <= (next_state == lpr_pkg::ST_SREF);
        end
    end
endmodule

// ### verilog/lpr_defines.svh
// timing counts, command encodings and sizes for the refresh scheduling link
`ifndef LPR_DEFINES_SVH
`define LPR_DEFINES_SVH

`define LPR_CLK_MHZ 200
`define LPR_NUM_BANKS 8
`define LPR_PB_PER_AB 8
`define LPR_OWED_MAX 8

// times in ns, then cycles: least times round up, the interval rounds down
`define LPR_T_RFCAB_NS 130
`define LPR_T_RFCPB_NS 60
`define LPR_T_RRD_NS 10
`define LPR_T_RP_NS 18
`define LPR_T_REFI_NS 7800
`define LPR_RFCAB_CYC ((`LPR_T_RFCAB_NS * `LPR_CLK_MHZ + 999) / 1000)
`define LPR_RFCPB_CYC ((`LPR_T_RFCPB_NS * `LPR_CLK_MHZ + 999) / 1000)
`define LPR_RRD_CYC ((`LPR_T_RRD_NS * `LPR_CLK_MHZ + 999) / 1000)
`define LPR_RP_CYC ((`LPR_T_RP_NS * `LPR_CLK_MHZ + 999) / 1000)
`define LPR_REFI_CYC ((`LPR_T_REFI_NS * `LPR_CLK_MHZ) / 1000)
`define LPR_REFI_PB_CYC (`LPR_REFI_CYC / `LPR_PB_PER_AB)

// command encodings on cmd_bit3..cmd_bit0 with chip select low
`define LPR_CA_REF 3'h4
`define LPR_CA_VAR_BIT 3
`define LPR_CA_ACT 4'h2
`define LPR_CA_PRE 4'hB
`define LPR_CA_PREALL 4'h3
`define LPR_CA_RESET 4'hF
`define LPR_CA_NOP 4'h7

`endif

// ### verilog/lpr_dev.sv
// memory device end: refresh decode, bank counter and per-bank availability
`timescale 1ns/1ps
`include "lpr_defines.svh"
module lpr_dev (
    input wire logic core_clk_in,
    input wire logic rst_in,
    lpr_link_if.dev link,
    output logic [7:0] bank_idle_out,
    output logic [7:0] bank_refreshing_out,
    output logic [2:0] ref_bank_out,
    output logic in_sref_out,
    output logic cmd_err_out
);
    localparam logic [7:0] RFCAB = 8'(`LPR_RFCAB_CYC);
    localparam logic [7:0] RFCPB = 8'(`LPR_RFCPB_CYC);

    logic [7:0] busy_cnt [8];
    logic [7:0] next_busy_cnt [8];
    logic [7:0] active, next_active, busy;
    logic [2:0] ctr, next_ctr;
    logic in_sr, next_err;
    logic sel, is_ref, is_ab, is_pb, sr_exit;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            busy[i] = (busy_cnt[i] != 8'h00);
        end
    end

    assign sel = link.cke & ~link.cs_n & ~in_sr;
    assign is_ref = sel & (link.ca[2:0] == `LPR_CA_REF);
    assign is_ab = is_ref & link.ca[`LPR_CA_VAR_BIT];
    assign is_pb = is_ref & ~link.ca[`LPR_CA_VAR_BIT];
    assign sr_exit = in_sr & link.cke;

    always_comb begin
        next_active = active;
        next_ctr = ctr;
        next_err = 1'b0;
        for (int i = 0; i < 8; i++) begin
            next_busy_cnt[i] = busy[i] ? busy_cnt[i] - 8'h01 : 8'h00;
        end
        if (sr_exit) begin
            next_ctr = 3'h0;
        end else if (is_pb) begin
            if (`LPR_NUM_BANKS != 8 || active[ctr] || busy[ctr]) begin
                next_err = 1'b1;
            end else begin
                next_busy_cnt[ctr] = RFCPB;
                next_ctr = ctr + 3'h1;
            end
        end else if (is_ab) begin
            if ((|active) || (|busy)) begin
                next_err = 1'b1;
            end else begin
                for (int i = 0; i < 8; i++) begin
                    next_busy_cnt[i] = RFCAB;
                end
                next_ctr = 3'h0;
            end
        end else if (sel && link.ca == `LPR_CA_RESET) begin
            next_ctr = 3'h0;
            next_active = 8'h00;
        end else if (sel && link.ca[1:0] == 2'(`LPR_CA_ACT)) begin
            if (busy[link.ba]) begin
                next_err = 1'b1;
            end else begin
                next_active[link.ba] = 1'b1;
            end
        end else if (sel && link.ca == `LPR_CA_PRE) begin
            next_active[link.ba] = 1'b0;
        end else if (sel && link.ca == `LPR_CA_PREALL) begin
            next_active = 8'h00;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 8; i++) begin
                busy_cnt[i] <= 8'h00;
            end
            active <= 8'h00;
            ctr <= 3'h0;
        end else begin
            busy_cnt <= next_busy_cnt;
            active <= next_active;
            ctr <= next_ctr;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            in_sr <= 1'b0;
        end else begin
            in_sr <= ~link.cke;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bank_idle_out <= 8'hFF;
            bank_refreshing_out <= 8'h00;
            ref_bank_out <= 3'h0;
            in_sref_out <= 1'b0;
            cmd_err_out <= 1'b0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                bank_idle_out[i] <= ~next_active[i] & (next_busy_cnt[i] == 8'h00);
                bank_refreshing_out[i] <= (next_busy_cnt[i] != 8'h00);
            end
            ref_bank_out <= next_ctr;
            in_sref_out <= ~link.cke;
            cmd_err_out <= next_err;
        end
    end
endmodule

// ### verilog/lpr_link_if.sv
// command/address link between the controller and the memory device
`timescale 1ns/1ps
interface lpr_link_if;
    logic cke;
    logic cs_n;
    logic [3:0] ca;
    logic [2:0] ba;

    modport ctl (output cke, output cs_n, output ca, output ba);
    modport dev (input cke, input cs_n, input ca, input ba);
endinterface

// ### verilog/lpr_pkg.sv
// types of the controller end of the refresh scheduling link, also used by the bench
package lpr_pkg;
    typedef enum logic [2:0] {
        ST_INIT = 3'h1,
        ST_RUN = 3'h2,
        ST_SREF = 3'h4
    } lpr_ctl_state_t;

    typedef enum logic [1:0] {
        OP_NOP = 2'h0,
        OP_ACT = 2'h1,
        OP_PRE = 2'h2,
        OP_PREALL = 2'h3
    } lpr_op_t;
endpackage
